// *** logic/cnttmr_top.sv ***
// Purpose: 32-bit counter/timer with prescaler, match and capture
// Assumes: one clock, synchronous active-low reset, plain register port
// Notes: capture pins are synchronised by two flip-flops
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "cnttmr_params.svh"

// Function
// - count advances every limit plus one count events (clocks in timer mode)
// - prescale at limit: count up, prescale clears
// - prescale counter readable and writable
// - writing flag register clears pending flags
// - reading flag register shows pending sources
// - control register enables or resets count
// - match resets, stops and/or interrupts
// - capture control selects edges and interrupt
// - capture input loads capture value register
// - external match control drives match pins
// - count control picks timer or counter mode
// - pulse width control per match pin
// - all implemented bits reset to zero
// - write one clears flag, zero keeps
// - flags 0-3 match, 4-5 capture
module cnttmr_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // pins
  input wire logic capture_input_0_in,
  input wire logic capture_input_1_in,
  output logic [3:0] match_outputs_out,
  output logic irq_out
);
  cnttmr_pkg::cnttmr_state_t st;
  cnttmr_pkg::cnttmr_state_t next_st;
  logic [1:0] sync_cap;
  logic [31:0] step_count;
  logic [31:0] step_pscnt;
  logic [3:0] m_flag;
  logic [3:0] m_reset;
  logic [3:0] m_stop;
  logic [3:0] m_pin;
  logic [1:0] c_load;
  logic [1:0] c_flag;
  logic [5:0] set_f;
  logic [5:0] clr_f;
  logic tick;
  logic cnt_ev;
  logic run;
  logic [2:0] cur;

  // capture pins pass two flip-flops first
  cnttmr_sync #(
    .WIDTH(2)
  ) cnttmr_sync_inst (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in({capture_input_1_in, capture_input_0_in}),
    .sync_out(sync_cap)
  );

  assign cur = {1'b0, sync_cap};
  assign run = st.tctrl[`CNTTMR_TCTRL_EN] &&
    !st.tctrl[`CNTTMR_TCTRL_RST];

  // counter mode picks the count event
  cnttmr_count_source cnttmr_count_source_inst (
    .level_in(sync_cap),
    .prev_in(st.cap_prev[1:0]),
    .mode_in(st.cntctrl),
    .event_out(cnt_ev)
  );

  cnttmr_count_step cnttmr_count_step_inst (
    .count_in(st.tcount),
    .prescale_in(st.pscnt),
    .limit_in(st.divlim),
    .run_in(run),
    .event_in(cnt_ev),
    .count_next_out(step_count),
    .prescale_next_out(step_pscnt),
    .tick_out(tick)
  );

  for (genvar gi = 0; gi < 4; gi++) begin : g_match
    cnttmr_match_unit cnttmr_match_unit_inst (
      .count_in(st.tcount),
      .value_in(st.mval[gi]),
      .tick_in(tick),
      .action_in(st.mctrl[3*gi +: 3]),
      .pin_action_in(st.emctrl[4+2*gi +: 2]),
      .pin_state_in(st.emctrl[gi]),
      .flag_out(m_flag[gi]),
      .reset_out(m_reset[gi]),
      .stop_out(m_stop[gi]),
      .pin_next_out(m_pin[gi])
    );
  end

  for (genvar gi = 0; gi < 2; gi++) begin : g_capture
    cnttmr_capture_unit cnttmr_capture_unit_inst (
      .level_in(sync_cap[gi]),
      .prev_in(st.cap_prev[gi]),
      .setup_in(st.cctrl[3*gi +: 3]),
      .load_out(c_load[gi]),
      .flag_out(c_flag[gi])
    );
  end

  always_comb begin
    next_st = st;
    set_f = {c_flag, m_flag};
    next_st.cap_prev = cur;
    next_st.tcount = step_count;
    next_st.pscnt = step_pscnt;
    if (st.tctrl[`CNTTMR_TCTRL_RST]) begin
      next_st.tcount = `CNTTMR_RESET_WORD;
      next_st.pscnt = `CNTTMR_RESET_WORD;
    end
    // match: any reset clears the count unless a stop also hits, any stop freezes it
    if (|m_reset) begin
      next_st.tcount = 32'h0000_0000;
    end
    if (|m_stop) begin
      next_st.tcount = st.tcount;
      next_st.pscnt = 32'h0000_0000;
      next_st.tctrl[`CNTTMR_TCTRL_EN] = 1'b0;
    end
    next_st.emctrl[3:0] = m_pin;
    for (int i = 0; i < 2; i++) begin
      if (c_load[i]) begin
        next_st.cval[i] = st.tcount;
      end
    end
    clr_f = 6'h00;
    if (wr_in) begin
      case (addr_in)
        `CNTTMR_OFS_IFLAG: clr_f = wdata_in[5:0];
        `CNTTMR_OFS_TCTRL: next_st.tctrl = wdata_in[1:0];
        `CNTTMR_OFS_TCOUNT: next_st.tcount = wdata_in;
        `CNTTMR_OFS_DIVLIM: next_st.divlim = wdata_in;
        `CNTTMR_OFS_PSCNT: next_st.pscnt = wdata_in;
        `CNTTMR_OFS_MCTRL: next_st.mctrl = wdata_in[11:0];
        `CNTTMR_OFS_MVAL0: next_st.mval[0] = wdata_in;
        `CNTTMR_OFS_MVAL1: next_st.mval[1] = wdata_in;
        `CNTTMR_OFS_MVAL2: next_st.mval[2] = wdata_in;
        `CNTTMR_OFS_MVAL3: next_st.mval[3] = wdata_in;
        `CNTTMR_OFS_CCTRL: next_st.cctrl = wdata_in[5:0];
        `CNTTMR_OFS_EMCTRL: next_st.emctrl = wdata_in[11:0];
        `CNTTMR_OFS_CNTCTRL: next_st.cntctrl = wdata_in[3:0];
        `CNTTMR_OFS_PWCTRL: next_st.pwctrl = wdata_in[3:0];
        `CNTTMR_OFS_IMASK: next_st.imask = wdata_in[5:0];
        default: ;
      endcase
    end
    // set wins over clear
    next_st.iflag = (st.iflag & ~clr_f) | set_f;
    next_st.rdata = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        `CNTTMR_OFS_IFLAG: next_st.rdata = {26'h0, st.iflag};
        `CNTTMR_OFS_TCTRL: next_st.rdata = {30'h0, st.tctrl};
        `CNTTMR_OFS_TCOUNT: next_st.rdata = st.tcount;
        `CNTTMR_OFS_DIVLIM: next_st.rdata = st.divlim;
        `CNTTMR_OFS_PSCNT: next_st.rdata = st.pscnt;
        `CNTTMR_OFS_MCTRL: next_st.rdata = {20'h0, st.mctrl};
        `CNTTMR_OFS_MVAL0: next_st.rdata = st.mval[0];
        `CNTTMR_OFS_MVAL1: next_st.rdata = st.mval[1];
        `CNTTMR_OFS_MVAL2: next_st.rdata = st.mval[2];
        `CNTTMR_OFS_MVAL3: next_st.rdata = st.mval[3];
        `CNTTMR_OFS_CCTRL: next_st.rdata = {26'h0, st.cctrl};
        `CNTTMR_OFS_CVAL0: next_st.rdata = st.cval[0];
        `CNTTMR_OFS_CVAL1: next_st.rdata = st.cval[1];
        `CNTTMR_OFS_EMCTRL: next_st.rdata = {20'h0, st.emctrl};
        `CNTTMR_OFS_CNTCTRL: next_st.rdata = {28'h0, st.cntctrl};
        `CNTTMR_OFS_PWCTRL: next_st.rdata = {28'h0, st.pwctrl};
        `CNTTMR_OFS_IMASK: next_st.rdata = {26'h0, st.imask};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    next_st.irq = |(next_st.iflag & next_st.imask);
    // pwm: pin high while count is below match value
    for (int i = 0; i < 4; i++) begin
      next_st.mat[i] = next_st.pwctrl[i] ?
        (next_st.tcount < next_st.mval[i]) : next_st.emctrl[i];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
  assign irq_out = st.irq;
  assign match_outputs_out = st.mat;
endmodule

module cnttmr_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } cnttmr_sync_state_t;
  cnttmr_sync_state_t st;
  cnttmr_sync_state_t next_st;

  // the first stage feeds only the second
  always_comb begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;
endmodule

module cnttmr_count_source (
  // synchronised pins and their previous levels
  input wire logic [1:0] level_in,
  input wire logic [1:0] prev_in,
  // count control field
  input wire logic [3:0] mode_in,
  // one count event
  output logic event_out
);
  logic sel_level;
  logic sel_prev;

  // bits 1:0 mode (0 timer, 1 rise, 2 fall, 3 both), bit 2 input select
  always_comb begin
    sel_level = level_in[mode_in[2]];
    sel_prev = prev_in[mode_in[2]];
    case (mode_in[1:0])
      2'h0: event_out = 1'b1;
      2'h1: event_out = sel_level && !sel_prev;
      2'h2: event_out = !sel_level && sel_prev;
      default: event_out = sel_level != sel_prev;
    endcase
  end
endmodule

module cnttmr_count_step (
  // present count and prescale state
  input wire logic [31:0] count_in,
  input wire logic [31:0] prescale_in,
  input wire logic [31:0] limit_in,
  // counting enabled and a count event due
  input wire logic run_in,
  input wire logic event_in,
  // next values and the end of a prescale period
  output logic [31:0] count_next_out,
  output logic [31:0] prescale_next_out,
  output logic tick_out
);
  always_comb begin
    tick_out = run_in && event_in && (prescale_in == limit_in);
    count_next_out = count_in;
    prescale_next_out = prescale_in;
    if (run_in && event_in) begin
      if (tick_out) begin
        prescale_next_out = 32'h0000_0000;
        count_next_out = count_in + 32'h0000_0001;
      end else begin
        prescale_next_out = prescale_in + 32'h0000_0001;
      end
    end
  end
endmodule

module cnttmr_match_unit (
  // count, match value and prescale tick
  input wire logic [31:0] count_in,
  input wire logic [31:0] value_in,
  input wire logic tick_in,
  // bit 0 interrupt, bit 1 reset, bit 2 stop
  input wire logic [2:0] action_in,
  // pin action (1 low, 2 high, 3 toggle) and present level
  input wire logic [1:0] pin_action_in,
  input wire logic pin_state_in,
  // what this channel asks for
  output logic flag_out,
  output logic reset_out,
  output logic stop_out,
  output logic pin_next_out
);
  logic hit;

  always_comb begin
    hit = (value_in == count_in) && tick_in;
    flag_out = hit && action_in[0];
    reset_out = hit && action_in[1];
    stop_out = hit && action_in[2];
    pin_next_out = pin_state_in;
    if (hit) begin
      case (pin_action_in)
        2'h1: pin_next_out = 1'b0;
        2'h2: pin_next_out = 1'b1;
        2'h3: pin_next_out = !pin_state_in;
        default: pin_next_out = pin_state_in;
      endcase
    end
  end
endmodule

module cnttmr_capture_unit (
  // present and previous synchronised level
  input wire logic level_in,
  input wire logic prev_in,
  // bit 0 rising, bit 1 falling, bit 2 interrupt
  input wire logic [2:0] setup_in,
  // load the capture register, raise its flag
  output logic load_out,
  output logic flag_out
);
  always_comb begin
    load_out = (setup_in[0] && level_in && !prev_in) ||
      (setup_in[1] && !level_in && prev_in);
    flag_out = load_out && setup_in[2];
  end
endmodule

// *** logic/cnttmr_params.svh ***
// Purpose: register offsets, field positions and reset values of the timer
// Assumes: byte offsets on a 32-bit word bus
// Notes: field layouts of control registers are chosen for this block
`ifndef CNTTMR_PARAMS_SVH
`define CNTTMR_PARAMS_SVH

`define CNTTMR_OFS_IFLAG 8'h00
`define CNTTMR_OFS_TCTRL 8'h04
`define CNTTMR_OFS_TCOUNT 8'h08
`define CNTTMR_OFS_DIVLIM 8'h0c
`define CNTTMR_OFS_PSCNT 8'h10
`define CNTTMR_OFS_MCTRL 8'h14
`define CNTTMR_OFS_MVAL0 8'h18
`define CNTTMR_OFS_MVAL1 8'h1c
`define CNTTMR_OFS_MVAL2 8'h20
`define CNTTMR_OFS_MVAL3 8'h24
`define CNTTMR_OFS_CCTRL 8'h28
`define CNTTMR_OFS_CVAL0 8'h2c
`define CNTTMR_OFS_CVAL1 8'h30
`define CNTTMR_OFS_EMCTRL 8'h3c
`define CNTTMR_OFS_CNTCTRL 8'h70
`define CNTTMR_OFS_PWCTRL 8'h74
`define CNTTMR_OFS_IMASK 8'h78

`define CNTTMR_TCTRL_EN 0
`define CNTTMR_TCTRL_RST 1
`define CNTTMR_NFLAGS 6
`define CNTTMR_RESET_WORD 32'h0000_0000

`endif

// *** logic/cnttmr_pkg.sv ***
// Purpose: shared types of the counter/timer
// Assumes: used with cnttmr_params.svh
// Notes: none
package cnttmr_pkg;
  typedef struct packed {
    logic [5:0] iflag;
    logic [5:0] imask;
    logic [1:0] tctrl;
    logic [31:0] tcount;
    logic [31:0] divlim;
    logic [31:0] pscnt;
    logic [11:0] mctrl;
    logic [3:0][31:0] mval;
    logic [5:0] cctrl;
    logic [1:0][31:0] cval;
    logic [11:0] emctrl;
    logic [3:0] cntctrl;
    logic [3:0] pwctrl;
    logic [2:0] cap_prev;
    logic [31:0] rdata;
    logic irq;
    logic [3:0] mat;
  } cnttmr_state_t;
endpackage

// *** verif/cnttmr_monitor.sv ***
// Purpose: port checks of the timer
// Assumes: one clock, sync reset
// Notes: mask at 0x78
`timescale 1ns/1ps
module cnttmr_monitor (
  // watched ports
  input wire logic clk_in, resetn_in, wr_in, rd_in,
  input wire logic capture_input_0_in, capture_input_1_in, irq_out,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in, rdata_out,
  input wire logic [3:0] match_outputs_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_in |=>
    !irq_out && rdata_out == 32'h0 && match_outputs_out == 4'h0)
    else $error("reset not quiet");
  a_rsv_read: assert property (rd_in && addr_in inside
    {[8'h34:8'h38], [8'h40:8'h6c], [8'h7c:8'hff]} |=> rdata_out == 32'h0)
    else $error("reserved read");
  a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("stray read data");
  a_flag_hi: assert property ($past(rd_in) && $past(addr_in) == 8'h00
    |-> rdata_out[31:6] == 26'h0) else $error("flag high bits");
  a_ctrl_hi: assert property ($past(rd_in) && $past(addr_in) == 8'h04
    |-> rdata_out[31:2] == 30'h0) else $error("control high bits");
  a_mask_hi: assert property ($past(rd_in) && $past(addr_in) == 8'h78
    |-> rdata_out[31:6] == 26'h0) else $error("mask high bits");
  a_zero_keeps: assert property (irq_out && !$past(wr_in) &&
    wr_in && addr_in == 8'h00 && wdata_in[5:0] == 6'h0 |=> irq_out)
    else $error("zero write cleared");
  a_mask_off: assert property (wr_in && addr_in == 8'h78 &&
    wdata_in[5:0] == 6'h0 ##1 !(wr_in && addr_in == 8'h78) |=> !irq_out)
    else $error("irq while masked");
endmodule
bind cnttmr_top cnttmr_monitor cnttmr_monitor_inst (.*);

// *** verif/cnttmr_top_tb.sv ***
// Purpose: directed test of the timer
// Assumes: 100 MHz clock, sync reset
// Notes: prescale, match, irq, capture
`timescale 1ns/1ps
module cnttmr_top_tb;
  logic clk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic capture_input_0_in = 1'b0, capture_input_1_in = 1'b0, irq_out;
  logic [7:0] addr_in = 8'h0;
  logic [31:0] wdata_in = 32'h0, rdata_out, got, pins;
  logic [3:0] match_outputs_out;
  int mismatches = 0, n_compared = 0;
  always #5 clk_in = ~clk_in;
  cnttmr_top cnttmr_top_inst (.*);
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    n_compared++;
    mismatches += int'(s !== e);
    if (s !== e) $display("[FAIL] %s exp %h got %h", n, e, s);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge clk_in) wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, bit c = 1'b1);
    {addr_in, rd_in} <= {a, 1'b1};
    @(posedge clk_in) rd_in <= 1'b0;
    @(negedge clk_in) got = rdata_out;
    pins = {27'h0, irq_out, match_outputs_out};
    if (c) check($sformatf("reg %h", a), got, e);
    @(posedge clk_in);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20us mismatches++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    wr(8'h34, 32'hffff_ffff);
    for (int a = 0; a < 124; a += 4) rd(8'(a), 32'h0);
    wr(8'h10, 32'h2);
    rd(8'h10, 32'h2);
    wr(8'h0c, 32'h3);
    wr(8'h04, 32'h1);
    rd(8'h08, 32'h0);
    repeat (38) @(posedge clk_in);
    rd(8'h08, 32'ha);
    wr(8'h04, 32'h2);
    rd(8'h08, 32'h0);
    wr(8'h18, 32'h5);
    wr(8'h14, 32'h5);
    wr(8'h3c, 32'h30);
    wr(8'h04, 32'h1);
    repeat (40) @(posedge clk_in);
    rd(8'h08, 32'h5);
    wr(8'h78, 32'h1);
    rd(8'h00, 32'h1);
    check("pins", pins, 32'h11);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h1);
    check("pins", pins, 32'h11);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h0);
    wr(8'h78, 32'h0);
    wr(8'h28, 32'h35);
    {capture_input_0_in, capture_input_1_in} <= 2'h3;
    repeat (8) @(posedge clk_in);
    rd(8'h00, 32'h10);
    capture_input_1_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    wr(8'h2c, 32'h0);
    rd(8'h2c, 32'h5);
    rd(8'h30, 32'h5);
    rd(8'h00, 32'h30);
    wr(8'h0c, 32'h0);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h3);
    wr(8'h74, 32'h1);
    wr(8'h70, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h1);
    for (int k = 1; k < 5; k++) begin
      capture_input_0_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      capture_input_0_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      if (k > 2) rd(8'h08, (k == 3) ? 32'h3 : 32'h0);
      if (k > 2) check("pwm pins", pins, (k == 3) ? 32'h0 : 32'h1);
    end
    $display("test sequence done");
    print_verdict();
  end
endmodule
